// ### hw/ess_map.vh
// ess_map.vh: select codes, output field layout and supervisor timing
// assumes: included by the decoder and top design files of the electrode select supervisor
`ifndef ESS_MAP_VH
`define ESS_MAP_VH

// terminal select codes
`define ESS_CODE_SOURCE 4'h0
`define ESS_CODE_E1 4'h1
`define ESS_CODE_E9 4'h9
`define ESS_CODE_REF_A 4'ha
`define ESS_CODE_REF_B 4'hb
`define ESS_CODE_OSC 4'hc
`define ESS_CODE_OSC_RES 4'hd
`define ESS_CODE_GND 4'he
`define ESS_CODE_RSVD 4'hf

// widths and field positions
`define ESS_CODE_W 4
`define ESS_N_ELEC 9
`define ESS_N_REF 2
`define ESS_N_TERM 11
`define ESS_N_INT 4
`define ESS_INT_SOURCE 0
`define ESS_INT_OSC 1
`define ESS_INT_OSC_RES 2
`define ESS_INT_GND 3

// reset values
`define ESS_ELEC_RST 9'h000
`define ESS_REF_RST 2'h0
`define ESS_INT_RST 4'h1
`define ESS_GND_RST 9'h1ff

// oscillator and supervisor timing, in ms and in oscillator cycles
`define ESS_OSC_HZ 120000
`define ESS_POR_MS 20
`define ESS_WD_MS 68
`define ESS_WD_HOLD_MS 20
`define ESS_POR_OSC ((`ESS_POR_MS * `ESS_OSC_HZ) / 1000)
`define ESS_WD_OSC ((`ESS_WD_MS * `ESS_OSC_HZ) / 1000)
`define ESS_WD_HOLD_OSC ((`ESS_WD_HOLD_MS * `ESS_OSC_HZ) / 1000)
`define ESS_TMR_W 14

// system clock
`define ESS_CLK_NS 10

`endif

// ### hw/ess_sync.v
// ess_sync: two flip-flop synchroniser for asynchronous pins, any width
// assumes: one clock domain, async active-low reset
`timescale 1ns/1ns
module ess_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  clk,
  reset_n,
  d_async,
  q_sync
);
  input wire clk;
  input wire reset_n;
  input wire [WIDTH-1:0] d_async;
  output reg [WIDTH-1:0] q_sync;

  reg [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= RST_VAL;
      q_sync <= RST_VAL;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end
endmodule // ess_sync

// ### hw/ess_tsel_decode.v
// ess_tsel_decode: turns a 4-bit terminal select code into one-hot selects
// assumes: code is already synchronised; the caller registers the outputs
`timescale 1ns/1ns
`include "ess_map.vh"
module ess_tsel_decode (
  code,
  elec_sel,
  ref_sel,
  int_sel
);
  input wire [`ESS_CODE_W-1:0] code;
  output reg [`ESS_N_ELEC-1:0] elec_sel;
  output reg [`ESS_N_REF-1:0] ref_sel;
  output reg [`ESS_N_INT-1:0] int_sel;

  // one-hot of a code, at most one bit set
  function [15:0] ess_onehot;
    input [`ESS_CODE_W-1:0] c;
    begin
      ess_onehot = 16'h0001 << c;
    end
  endfunction

  reg [15:0] oh;

  always @* begin
    oh = ess_onehot(code);
    elec_sel = oh[`ESS_CODE_E9:`ESS_CODE_E1];
    ref_sel = oh[`ESS_CODE_REF_B:`ESS_CODE_REF_A];
    int_sel[`ESS_INT_SOURCE] = oh[`ESS_CODE_SOURCE];
    int_sel[`ESS_INT_OSC] = oh[`ESS_CODE_OSC];
    int_sel[`ESS_INT_OSC_RES] = oh[`ESS_CODE_OSC_RES];
    int_sel[`ESS_INT_GND] = oh[`ESS_CODE_GND];
    // reserved code selects nothing
  end
endmodule // ess_tsel_decode

// ### hw/ess_electrode_select_supervisor.v
// ess_electrode_select_supervisor: terminal select multiplexer control,
// grounding switches, square clock output and supply/watchdog supervisor.
// assumes: osc_sq is the square form of the analog sine oscillator; supply
// comparators and the select and kick pins are asynchronous to clk.
//
// How it works
// - the controller's 4-bit code, D high and A low, picks electrodes 1..9 with codes 1..9 and references A and B with 10 and 11.
// - code 0 routes the internal source, 12 the oscillator, 13 the oscillator after its resistor, 14 internal ground, 15 is reserved.
// - every sensing electrode that is not selected has its grounding switch closed.
// - the reference terminals are never grounded, selected or not.
// - at most one terminal is driven at a time and the choice follows only the current code.
// - the receive multiplexer picks the very terminal that is driven, switching in the same cycle.
// - the selected electrode or reference terminal is switched onto the shield driver input.
// - the clock output is a square wave at the oscillator frequency.
// - supervisor time-outs count oscillator cycles, and power-on reset lasts 9 to 50 ms.
// - the watchdog fires after 50 to 250 ms (68 typical) without service and then holds reset 9 to 50 ms.
// - the controller must give rising edges on the kick input often enough, else reset is pulled low.
// - reset stays low until supply has stayed good for the time-out, and restarts on any dip.
// - an over-voltage supply forces reset low.
`timescale 1ns/1ns
`include "ess_map.vh"
module ess_electrode_select_supervisor #(
  parameter POR_OSC = `ESS_POR_OSC,
  parameter WD_OSC = `ESS_WD_OSC,
  parameter WD_HOLD_OSC = `ESS_WD_HOLD_OSC
) (
  clk,
  reset_n,
  terminal_select_code,
  watchdog_kick_input,
  osc_sq,
  vcc_above_min,
  vcc_above_max,
  elec_drive_sel,
  ref_drive_sel,
  int_node_sel,
  elec_ground_en,
  rx_elec_sel,
  rx_ref_sel,
  rx_int_sel,
  shield_in_sel,
  clk_out,
  mcu_reset_n
);
  input wire clk;
  input wire reset_n;
  input wire [`ESS_CODE_W-1:0] terminal_select_code;
  input wire watchdog_kick_input;
  input wire osc_sq;
  input wire vcc_above_min;
  input wire vcc_above_max;
  output reg [`ESS_N_ELEC-1:0] elec_drive_sel;
  output reg [`ESS_N_REF-1:0] ref_drive_sel;
  output reg [`ESS_N_INT-1:0] int_node_sel;
  output reg [`ESS_N_ELEC-1:0] elec_ground_en;
  output reg [`ESS_N_ELEC-1:0] rx_elec_sel;
  output reg [`ESS_N_REF-1:0] rx_ref_sel;
  output reg [`ESS_N_INT-1:0] rx_int_sel;
  output reg [`ESS_N_TERM-1:0] shield_in_sel;
  output reg clk_out;
  output reg mcu_reset_n;

  localparam [1:0] ST_POR = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;

  // last count of a time-out, cut to the timer width
  function [`ESS_TMR_W-1:0] ess_tmr_last;
    input integer ticks;
    integer n;
    begin
      n = ticks - 1;
      ess_tmr_last = n[`ESS_TMR_W-1:0];
    end
  endfunction

  // timer step, wraps within its width
  function [`ESS_TMR_W-1:0] ess_tmr_inc;
    input [`ESS_TMR_W-1:0] t;
    begin
      ess_tmr_inc = t + {{(`ESS_TMR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // tick that ends a time-out
  function ess_tmr_done;
    input [`ESS_TMR_W-1:0] t;
    input [`ESS_TMR_W-1:0] last;
    begin
      ess_tmr_done = (t == last);
    end
  endfunction

  localparam [`ESS_TMR_W-1:0] POR_LAST = ess_tmr_last(POR_OSC);
  localparam [`ESS_TMR_W-1:0] WD_LAST = ess_tmr_last(WD_OSC);
  localparam [`ESS_TMR_W-1:0] HOLD_LAST = ess_tmr_last(WD_HOLD_OSC);

  // synchronised pins
  wire [`ESS_CODE_W-1:0] code_s;
  wire kick_s;
  wire osc_s;
  wire vmin_s;
  wire vmax_s;

  ess_sync #(
    .WIDTH(`ESS_CODE_W),
    .RST_VAL(`ESS_CODE_SOURCE)
  ) u_code_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d_async(terminal_select_code),
    .q_sync(code_s)
  );

  // kick pin, idle low so no false edge after reset
  ess_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_kick_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d_async(watchdog_kick_input),
    .q_sync(kick_s)
  );

  // oscillator square wave
  ess_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_osc_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d_async(osc_sq),
    .q_sync(osc_s)
  );

  // supply low comparator, reads bad until seen good
  ess_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_vmin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d_async(vcc_above_min),
    .q_sync(vmin_s)
  );

  // supply high comparator
  ess_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_vmax_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d_async(vcc_above_max),
    .q_sync(vmax_s)
  );

  // decode of the synchronised code
  wire [`ESS_N_ELEC-1:0] dec_elec;
  wire [`ESS_N_REF-1:0] dec_ref;
  wire [`ESS_N_INT-1:0] dec_int;

  ess_tsel_decode u_decode (
    .code(code_s),
    .elec_sel(dec_elec),
    .ref_sel(dec_ref),
    .int_sel(dec_int)
  );

  // edge detection on synchronised levels
  reg kick_d_r;
  reg osc_d_r;
  wire kick_rise;
  wire osc_tick;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kick_d_r <= 1'b0;
      osc_d_r <= 1'b0;
    end else begin
      kick_d_r <= kick_s;
      osc_d_r <= osc_s;
    end
  end

  assign kick_rise = kick_s & ~kick_d_r;
  assign osc_tick = osc_s & ~osc_d_r;

  // multiplexer and switch outputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      elec_drive_sel <= `ESS_ELEC_RST;
      ref_drive_sel <= `ESS_REF_RST;
      int_node_sel <= `ESS_INT_RST;
      elec_ground_en <= `ESS_GND_RST;
      rx_elec_sel <= `ESS_ELEC_RST;
      rx_ref_sel <= `ESS_REF_RST;
      rx_int_sel <= `ESS_INT_RST;
      shield_in_sel <= {`ESS_N_TERM{1'b0}};
    end else begin
      elec_drive_sel <= dec_elec;
      ref_drive_sel <= dec_ref;
      int_node_sel <= dec_int;
      elec_ground_en <= ~dec_elec;
      rx_elec_sel <= dec_elec;
      rx_ref_sel <= dec_ref;
      rx_int_sel <= dec_int;
      shield_in_sel <= {dec_ref, dec_elec};
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= osc_s;
    end
  end

  // supervisor
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`ESS_TMR_W-1:0] tmr_r;
  reg [`ESS_TMR_W-1:0] tmr_nxt;
  reg rst_nxt;
  wire supply_bad;

  assign supply_bad = ~vmin_s | vmax_s;

  always @* begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    rst_nxt = 1'b0;
    case (state_r)
      ST_POR: begin
        if (osc_tick) begin
          if (ess_tmr_done(tmr_r, POR_LAST)) begin
            state_nxt = ST_RUN;
            tmr_nxt = {`ESS_TMR_W{1'b0}};
            rst_nxt = 1'b1;
          end else begin
            tmr_nxt = ess_tmr_inc(tmr_r);
          end
        end
      end
      ST_RUN: begin
        rst_nxt = 1'b1;
        if (kick_rise) begin
          tmr_nxt = {`ESS_TMR_W{1'b0}};
        end else if (osc_tick) begin
          if (ess_tmr_done(tmr_r, WD_LAST)) begin
            state_nxt = ST_HOLD;
            tmr_nxt = {`ESS_TMR_W{1'b0}};
            rst_nxt = 1'b0;
          end else begin
            tmr_nxt = ess_tmr_inc(tmr_r);
          end
        end
      end
      ST_HOLD: begin
        if (osc_tick) begin
          if (ess_tmr_done(tmr_r, HOLD_LAST)) begin
            state_nxt = ST_RUN;
            tmr_nxt = {`ESS_TMR_W{1'b0}};
            rst_nxt = 1'b1;
          end else begin
            tmr_nxt = ess_tmr_inc(tmr_r);
          end
        end
      end
      default: begin
        state_nxt = ST_POR;
        tmr_nxt = {`ESS_TMR_W{1'b0}};
      end
    endcase
    if (supply_bad) begin
      state_nxt = ST_POR;
      tmr_nxt = {`ESS_TMR_W{1'b0}};
      rst_nxt = 1'b0;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_POR;
      tmr_r <= {`ESS_TMR_W{1'b0}};
      mcu_reset_n <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      mcu_reset_n <= rst_nxt;
    end
  end
endmodule // ess_electrode_select_supervisor

// ### testbench/ess_checker.sv
// ess_checker: port assertions for the electrode select supervisor
// assumes: bound to the top module, single clock, async active-low reset
`timescale 1ns/1ns
module ess_checker (
  input wire clk,
  input wire reset_n,
  input wire [3:0] terminal_select_code,
  input wire osc_sq,
  input wire vcc_above_min,
  input wire vcc_above_max,
  input wire [8:0] elec_drive_sel,
  input wire [1:0] ref_drive_sel,
  input wire [3:0] int_node_sel,
  input wire [8:0] elec_ground_en,
  input wire [8:0] rx_elec_sel,
  input wire [1:0] rx_ref_sel,
  input wire [3:0] rx_int_sel,
  input wire [10:0] shield_in_sel,
  input wire clk_out,
  input wire mcu_reset_n
);
  wire [3:0] c = terminal_select_code;
  reg [7:0] good_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles of good supply
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n || !vcc_above_min || vcc_above_max) good_r <= 8'h00;
    else if (good_r != 8'hff) good_r <= good_r + 8'h01;
  end
  sequence code_held;
    $stable(c) [*6];
  endsequence
  sel_elec_a: assert property (code_held |->
    elec_drive_sel == ((c != 4'h0 && c < 4'ha) ? 9'h001 << (c - 4'h1) : 9'h000))
    else $error("electrode drive wrong");
  sel_ref_a: assert property (code_held |-> ref_drive_sel == {c == 4'hb, c == 4'ha})
    else $error("reference drive wrong");
  sel_int_a: assert property (code_held |->
    int_node_sel == {c == 4'he, c == 4'hd, c == 4'hc, c == 4'h0})
    else $error("internal node wrong");
  gnd_unsel_a: assert property (elec_ground_en == ~elec_drive_sel)
    else $error("grounding wrong");
  one_drive_a: assert property ($onehot0({ref_drive_sel, elec_drive_sel, int_node_sel}))
    else $error("several driven");
  rx_follow_a: assert property ({rx_elec_sel, rx_ref_sel, rx_int_sel} ==
    {elec_drive_sel, ref_drive_sel, int_node_sel})
    else $error("receive differs");
  shield_sel_a: assert property (shield_in_sel == {ref_drive_sel, elec_drive_sel})
    else $error("shield input wrong");
  clk_follow_a: assert property ($rose(osc_sq) |-> ##[2:4] $rose(clk_out))
    else $error("clock output lost");
  supply_bad_a: assert property (!vcc_above_min || vcc_above_max |-> ##[1:4] !mcu_reset_n)
    else $error("reset not forced");
  por_wait_a: assert property ($rose(mcu_reset_n) |-> good_r >= 8'h32)
    else $error("reset released early");
endmodule // ess_checker

bind ess_electrode_select_supervisor ess_checker u_chk (.clk, .reset_n, .terminal_select_code,
  .osc_sq, .vcc_above_min, .vcc_above_max, .elec_drive_sel, .ref_drive_sel, .int_node_sel,
  .elec_ground_en, .rx_elec_sel, .rx_ref_sel, .rx_int_sel, .shield_in_sel, .clk_out,
  .mcu_reset_n);

// ### testbench/ess_mcu_model.sv
// ess_mcu_model: controller side, drives select code and watchdog kicks
// assumes: bench requests codes and enables kicking
`timescale 1ns/1ns
module ess_mcu_model (
  input wire clk,
  input wire kick_en,
  input wire [3:0] code_req,
  output reg [3:0] terminal_select_code = 4'h0,
  output reg watchdog_kick_input = 1'b0
);
  reg [5:0] cnt_r = 6'h00;
  always @(posedge clk) begin
    terminal_select_code <= code_req;
    cnt_r <= cnt_r + 6'h01;
    watchdog_kick_input <= kick_en & cnt_r[5];
  end
endmodule // ess_mcu_model

// ### testbench/tb_ess_electrode_select_supervisor.sv
// tb_ess_electrode_select_supervisor: self-checking bench
// assumes: short supervisor counts 4/8/4, osc_sq period 20 clk
`timescale 1ns/1ns
module tb_ess_electrode_select_supervisor;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg osc_sq = 1'b0;
  reg vcc_above_min = 1'b1;
  reg vcc_above_max = 1'b0;
  reg kick_en = 1'b0;
  reg [3:0] code_req = 4'h0;
  reg [3:0] osc_cnt = 4'h0;
  wire [3:0] terminal_select_code, int_node_sel, rx_int_sel;
  wire [8:0] elec_drive_sel, elec_ground_en, rx_elec_sel;
  wire [1:0] ref_drive_sel, rx_ref_sel;
  wire [10:0] shield_in_sel;
  wire watchdog_kick_input, clk_out, mcu_reset_n;
  integer failures = 0;
  integer cmp_count = 0;
  ess_mcu_model mcu (.clk, .kick_en, .code_req, .terminal_select_code, .watchdog_kick_input);
  ess_electrode_select_supervisor #(.POR_OSC(4), .WD_OSC(8), .WD_HOLD_OSC(4)) dut (.clk,
    .reset_n, .terminal_select_code, .watchdog_kick_input, .osc_sq, .vcc_above_min,
    .vcc_above_max, .elec_drive_sel, .ref_drive_sel, .int_node_sel, .elec_ground_en,
    .rx_elec_sel, .rx_ref_sel, .rx_int_sel, .shield_in_sel, .clk_out, .mcu_reset_n);
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt == 4'h9) ? 4'h0 : osc_cnt + 4'h1;
    if (osc_cnt == 4'h9) osc_sq <= ~osc_sq;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, got);
    cmp_count = cmp_count + 1;
    if (exp !== got) begin
      failures = failures + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_rng(input string what, input integer lo, hi, got);
    cmp_count = cmp_count + 1;
    if (got < lo || got > hi) begin
      failures = failures + 1;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task wait_rst(input logic lvl, input integer lim, output integer n);
    n = 0;
    while (mcu_reset_n !== lvl) begin
      @(negedge clk);
      n = n + 1;
      if (n > lim) begin
        failures = failures + 1;
        end_sim;
      end
    end
  endtask
  task t_sel;
    logic [8:0] e;
    logic [1:0] r;
    logic [3:0] i;
    integer k;
    for (k = 0; k < 16; k = k + 1) begin
      @(posedge clk);
      code_req <= k[3:0];
      repeat (8) @(negedge clk);
      e = (k >= 1 && k <= 9) ? 9'h001 << (k - 1) : 9'h000;
      r = {k == 11, k == 10};
      i = {k == 14, k == 13, k == 12, k == 0};
      chk("drive", {e, r, i, ~e}, {elec_drive_sel, ref_drive_sel, int_node_sel, elec_ground_en});
      chk("receive", {r, e, r, e, i}, {shield_in_sel, rx_ref_sel, rx_elec_sel, rx_int_sel});
    end
    $display("select test done");
  endtask
  task t_clk;
    integer n, k;
    logic p;
    n = 0;
    @(negedge clk);
    p = clk_out;
    for (k = 0; k < 200; k = k + 1) begin
      @(negedge clk);
      if (clk_out === 1'b1 && p === 1'b0) n = n + 1;
      p = clk_out;
    end
    chk("clk_out rises", 10, n);
    $display("clock test done");
  endtask
  task t_por;
    integer n;
    @(posedge clk);
    vcc_above_min <= 1'b0;
    wait_rst(1'b0, 6, n);
    chk_rng("dip", 0, 6, n);
    @(posedge clk);
    vcc_above_min <= 1'b1;
    wait_rst(1'b1, 300, n);
    chk_rng("por wait", 60, 110, n);
    @(posedge clk);
    vcc_above_max <= 1'b1;
    wait_rst(1'b0, 6, n);
    chk_rng("over voltage", 0, 6, n);
    @(posedge clk);
    vcc_above_max <= 1'b0;
    wait_rst(1'b1, 300, n);
    $display("supply test done");
  endtask
  task t_wd;
    integer n, k;
    n = 0;
    for (k = 0; k < 400; k = k + 1) begin
      @(negedge clk);
      if (mcu_reset_n !== 1'b1) n = n + 1;
    end
    chk("kicked lows", 0, n);
    for (k = 0; k < 40 && watchdog_kick_input !== 1'b0; k = k + 1) @(negedge clk);
    if (watchdog_kick_input !== 1'b0) begin
      failures = failures + 1;
      end_sim;
    end
    for (k = 0; k < 70 && watchdog_kick_input !== 1'b1; k = k + 1) @(negedge clk);
    if (watchdog_kick_input !== 1'b1) begin
      failures = failures + 1;
      end_sim;
    end
    @(posedge clk);
    kick_en <= 1'b0;
    wait_rst(1'b0, 400, n);
    chk_rng("wd timeout", 140, 200, n);
    wait_rst(1'b1, 300, n);
    chk_rng("wd hold", 60, 100, n);
    wait_rst(1'b0, 400, n);
    chk_rng("wd restart", 140, 180, n);
    @(posedge clk);
    kick_en <= 1'b1;
    wait_rst(1'b1, 300, n);
    $display("watchdog test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    kick_en <= 1'b1;
    t_sel;
    t_clk;
    t_por;
    t_wd;
    end_sim;
  end
endmodule // tb_ess_electrode_select_supervisor
